// ==== hw/clg_pkg.sv ====
package clg_pkg;

   // ------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [11:0] ADDR_GATE_IN     = 12'h000;  // gate inputs a..d, per block
   localparam logic [11:0] ADDR_GATE_INV    = 12'h004;  // per-input inversion masks
   localparam logic [11:0] ADDR_GATE_USED   = 12'h008;  // per-input connected masks
   localparam logic [11:0] ADDR_GATE_OUT    = 12'h00c;  // gate outputs (read only)
   localparam logic [11:0] ADDR_SB_CTRL     = 12'h010;  // special block control inputs
   localparam logic [11:0] ADDR_SB_TIMECFG  = 12'h014;  // timebase select and value
   localparam logic [11:0] ADDR_SB_STATUS   = 12'h018;  // special block output (read only)
   localparam logic [11:0] ADDR_SB_ELAPSED  = 12'h01c;  // stopwatch elapsed time, in hundredths, seconds or minutes for the seconds, minutes or hours timebase
   localparam logic [11:0] ADDR_SCAN        = 12'h020;  // write 1 to bit 0 to run one scan
   localparam logic [11:0] ADDR_NDO_LO      = 12'h040;  // network digital out 1..32
   localparam logic [11:0] ADDR_NDO_HI      = 12'h044;  // network digital out 33..64
   localparam logic [11:0] ADDR_NAO_BASE    = 12'h080;  // network analog outs, one word each

   // ------------------------------------------------------------
   // counts and field positions
   // ------------------------------------------------------------
   localparam int NDO_COUNT   = 64;
   localparam int NAO_COUNT   = 16;
   localparam int NAO_WIDTH   = 16;
   localparam int GATE_INPUTS = 4;

   // special block control bits
   localparam int SB_SET_BIT  = 0;
   localparam int SB_RST_BIT  = 1;
   localparam int SB_EN_BIT   = 2;
   localparam int SB_INV_BIT  = 3;
   localparam int SB_RALL_BIT = 4;
   localparam int SB_LAP_BIT  = 5;
   localparam int SB_RUN_BIT  = 6;
   localparam int SB_USED_LSB = 8;  // connected mask of the six logic inputs

   // reset values
   localparam logic [31:0] RST_GATE_INV  = 32'h0000_0000;
   localparam logic [31:0] RST_GATE_USED = 32'h0000_0000;
   localparam logic [31:0] RST_SB_CTRL   = 32'h0000_0000;
   localparam logic [31:0] RST_TIMECFG   = 32'h0000_0000;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_HZ     = 25_000_000;
   localparam int TICK_10MS  = 10;  // stopwatch base, ms
   localparam int TICK_10MS_CYCLES = CLK_HZ / 1000 * TICK_10MS;

   // 10 ms ticks per counted unit: hundredths, seconds, minutes
   localparam logic [12:0] UNIT_TICKS_SEC  = 13'h0001;
   localparam logic [12:0] UNIT_TICKS_MIN  = 13'h0064;
   localparam logic [12:0] UNIT_TICKS_HOUR = 13'h1770;

   typedef enum logic [1:0] {TB_SEC, TB_MIN, TB_HOUR, TB_10MS} clg_timebase_t;

endpackage : clg_pkg

// ==== hw/clg_net_out_mem.sv ====
`timescale 1ns/1ns
// holds the network analog outputs; read data is registered
module clg_net_out_mem
   import clg_pkg::*;
(
   input  wire logic                 core_clk,
   input  wire logic                 arst_n,
   input  wire logic                 wrEn,
   input  wire logic [3:0]           wrAddr,
   input  wire logic [NAO_WIDTH-1:0] wrData,
   input  wire logic [3:0]           rdAddr,
   output logic      [NAO_WIDTH-1:0] rdData,
   output logic      [NAO_WIDTH-1:0] firstWord
);

   logic [NAO_WIDTH-1:0] mem [NAO_COUNT];

   // ------------------------------------------------------------
   // storage, cleared at reset so outputs are defined
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < NAO_COUNT; i++) begin
            mem[i] <= '0;
         end
      end else if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
   end

   // registered read port
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdData <= '0;
      end else begin
         rdData <= mem[rdAddr];
      end
   end

   assign firstWord = mem[0];

endmodule : clg_net_out_mem

// ==== hw/clg_cycle_logic.sv ====
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ns
// Function
// - four-input and goes high only when all inputs high.
// - unconnected and/nand inputs, edge variants too, read as high.
// - rising and pulses when all high now and one was low before.
// - nand goes low only when all inputs high.
// - falling nand is high when one low now and all high before.
// - or is high when any input high.
// - nor is high only when all inputs low.
// - unconnected or/nor/xor inputs read as low.
// - xor is high when its two inputs differ.
// - not outputs the complement of its input.
// - every gate input has its own inversion before evaluation.
// - set drives the special block output high.
// - reset overrides everything and clears the outputs.
// - enable low makes the special block ignore all inputs but reset and reset-all.
// - invert input complements the special block output.
// - reset-all clears all internal values such as elapsed time.
// - pause suspends stopwatch accumulation.
// - unconnected special block logic inputs read as low.
// - time value is read according to the selected timebase.
// - stopwatch offers an extra 10 ms timebase.
// - 64 addressable network digital outputs.
// - 16 addressable network analog outputs.
module clg_cycle_logic
   import clg_pkg::*;
(
   input  wire logic                 core_clk,
   input  wire logic                 arst_n,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   output logic      [7:0]           gateOut,
   output logic                      specialOut,
   output logic                      scanDone,
   output logic      [NDO_COUNT-1:0] networkDigitalOut,
   output logic      [NAO_WIDTH-1:0] networkAnalogOut0
);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // condition an input: invert per its mask, then substitute the default when unused
   function automatic logic [3:0] condition(input logic [3:0] raw, input logic [3:0] inv,
                                           input logic [3:0] used, input logic dflt);
      condition = ((raw ^ inv) & used) | ({4{dflt}} & ~used);
   endfunction : condition

   function automatic logic wordHit(input logic [11:0] a, input logic [11:0] b);
      wordHit = (a[11:2] == b[11:2]);
   endfunction : wordHit

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   // gate block order in each register: 0 and, 1 and-edge, 2 nand, 3 nand-edge, 4 or, 5 nor, 6 xor, 7 not
   logic [31:0]          gateIn;     // 4 bits per block, a at the low end
   logic [31:0]          gateInv;
   logic [31:0]          gateUsed;
   logic [31:0]          sbCtrl;
   logic [31:0]          timeCfg;    // [1:0] timebase, [15:8] major, [23:16] minor
   logic [31:0]          elapsed;
   logic [3:0]           prevAndEdge;
   logic [3:0]           prevNandEdge;
   logic [12:0]          cntVal;
   logic [19:0]          tickCnt;
   logic                 scanReq;
   logic                 sbQ;
   logic                 naoWaited;  // first analog read cycle already spent
   logic [NAO_WIDTH-1:0] naoRd;

   wire logic access = psel && penable;
   wire logic wrAcc  = access && pwrite;

   // no error responses: unmapped places read zero and ignore writes
   assign pslverr = 1'b0;

   // ------------------------------------------------------------
   // software-written registers
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         gateIn   <= '0;
         gateInv  <= RST_GATE_INV;
         gateUsed <= RST_GATE_USED;
         sbCtrl   <= RST_SB_CTRL;
         timeCfg  <= RST_TIMECFG;
         networkDigitalOut <= '0;
      end else if (wrAcc) begin
         if (wordHit(paddr, ADDR_GATE_IN))    gateIn   <= pwdata;
         if (wordHit(paddr, ADDR_GATE_INV))   gateInv  <= pwdata;
         if (wordHit(paddr, ADDR_GATE_USED))  gateUsed <= pwdata;
         if (wordHit(paddr, ADDR_SB_CTRL))    sbCtrl   <= pwdata;
         if (wordHit(paddr, ADDR_SB_TIMECFG)) timeCfg  <= pwdata;
         if (wordHit(paddr, ADDR_NDO_LO))     networkDigitalOut[31:0]  <= pwdata;
         if (wordHit(paddr, ADDR_NDO_HI))     networkDigitalOut[63:32] <= pwdata;
      end
   end

   // scan request: one scan evaluates every gate once
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         scanReq <= 1'b0;
      end else begin
         scanReq <= wrAcc && wordHit(paddr, ADDR_SCAN) && pwdata[0];
      end
   end

   // ------------------------------------------------------------
   // analog network outputs
   // ------------------------------------------------------------
   wire logic naoHit   = (paddr[11:6] == ADDR_NAO_BASE[11:6]);
   wire logic naoRdAcc = access && !pwrite && naoHit;

   // analog reads need one wait state: the memory read register follows paddr at the
   // setup edge, so prdata can only pick the word up one access cycle later
   assign pready = !(naoRdAcc && !naoWaited);

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         naoWaited <= 1'b0;
      end else begin
         naoWaited <= naoRdAcc && !naoWaited;
      end
   end

   clg_net_out_mem u_nao (
      .core_clk  (core_clk),
      .arst_n    (arst_n),
      .wrEn      (wrAcc && naoHit),
      .wrAddr    (paddr[5:2]),
      .wrData    (pwdata[NAO_WIDTH-1:0]),
      .rdAddr    (paddr[5:2]),
      .rdData    (naoRd),
      .firstWord (networkAnalogOut0)
   );

   // ------------------------------------------------------------
   // gate evaluation
   // ------------------------------------------------------------
   logic [3:0] inAnd, inAndE, inNand, inNandE, inOr, inNor, inXor, inNot;
   logic [7:0] next_gateOut;

   always_comb begin
      inAnd   = condition(gateIn[3:0],   gateInv[3:0],   gateUsed[3:0],   1'b1);
      inAndE  = condition(gateIn[7:4],   gateInv[7:4],   gateUsed[7:4],   1'b1);
      inNand  = condition(gateIn[11:8],  gateInv[11:8],  gateUsed[11:8],  1'b1);
      inNandE = condition(gateIn[15:12], gateInv[15:12], gateUsed[15:12], 1'b1);
      inOr    = condition(gateIn[19:16], gateInv[19:16], gateUsed[19:16], 1'b0);
      inNor   = condition(gateIn[23:20], gateInv[23:20], gateUsed[23:20], 1'b0);
      inXor   = condition(gateIn[27:24], gateInv[27:24], gateUsed[27:24], 1'b0);
      inNot   = condition(gateIn[31:28], gateInv[31:28], 4'hf, 1'b0);
      next_gateOut[0] = &inAnd;
      next_gateOut[1] = (&inAndE) && !(&prevAndEdge);
      next_gateOut[2] = !(&inNand);
      next_gateOut[3] = !(&inNandE) && (&prevNandEdge);
      next_gateOut[4] = |inOr;
      next_gateOut[5] = !(|inNor);
      next_gateOut[6] = inXor[0] ^ inXor[1];
      next_gateOut[7] = !inNot[0];
   end

   // outputs and previous values update once per scan
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         gateOut      <= 8'h00;
         prevAndEdge  <= 4'hf;
         prevNandEdge <= 4'hf;
         scanDone     <= 1'b0;
      end else begin
         scanDone <= scanReq;
         if (scanReq) begin
            gateOut      <= next_gateOut;
            prevAndEdge  <= inAndE;
            prevNandEdge <= inNandE;
         end
      end
   end

   // ------------------------------------------------------------
   // special block: set/reset latch with stopwatch
   // ------------------------------------------------------------
   // unused logic inputs default low; inversion is not applied here
   wire logic [5:0] sbIn    = sbCtrl[5:0] & sbCtrl[SB_USED_LSB +: 6];
   wire logic       sbSet   = sbIn[SB_SET_BIT];
   wire logic       sbRst   = sbIn[SB_RST_BIT];
   wire logic       sbEn    = sbIn[SB_EN_BIT];
   wire logic       sbInv   = sbIn[SB_INV_BIT];
   wire logic       sbRall  = sbIn[SB_RALL_BIT];
   wire logic       sbLap   = sbIn[SB_LAP_BIT];
   wire logic       sbRun   = sbCtrl[SB_RUN_BIT];
   wire clg_timebase_t tb   = clg_timebase_t'(timeCfg[1:0]);

   // latched output; reset wins over set, enable gates everything else
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         sbQ <= 1'b0;
      end else if (sbRst || sbRall) begin
         sbQ <= 1'b0;
      end else if (sbEn && sbSet) begin
         sbQ <= 1'b1;
      end
   end

   // invert is an input too, so enable low keeps it from acting
   assign specialOut = sbRst ? 1'b0 : (sbQ ^ (sbInv && sbEn));

   // tick generator: 10 ms units, counted down from the clock
   wire logic tick = (tickCnt == 20'(TICK_10MS_CYCLES - 1));

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         tickCnt <= '0;
      end else if (sbRall || tick) begin
         tickCnt <= '0;
      end else begin
         tickCnt <= tickCnt + 20'h1;
      end
   end

   // timebase scaling: ticks per unit of the selected base
   // seconds base counts hundredths; minutes base counts seconds; hours base counts minutes
   logic [12:0] unitTicks;
   always_comb begin
      case (tb)
         TB_SEC:  unitTicks = UNIT_TICKS_SEC;
         TB_MIN:  unitTicks = UNIT_TICKS_MIN;
         TB_HOUR: unitTicks = UNIT_TICKS_HOUR;
         TB_10MS: unitTicks = UNIT_TICKS_SEC;
         default: unitTicks = UNIT_TICKS_SEC;
      endcase
   end

   // elapsed time accumulates while enabled and running and not paused
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         elapsed <= '0;
         cntVal  <= '0;
      end else if (sbRst || sbRall) begin
         elapsed <= '0;
         cntVal  <= '0;
      end else if (tick && sbEn && sbRun && !sbLap) begin
         if (cntVal >= unitTicks - 13'h1) begin
            cntVal  <= '0;
            elapsed <= elapsed + 32'h1;
         end else begin
            cntVal <= cntVal + 13'h1;
         end
      end
   end

   // ------------------------------------------------------------
   // read data, registered
   // ------------------------------------------------------------
   logic [31:0] next_prdata;
   always_comb begin
      next_prdata = 32'h0000_0000;
      if (wordHit(paddr, ADDR_GATE_IN))    next_prdata = gateIn;
      if (wordHit(paddr, ADDR_GATE_INV))   next_prdata = gateInv;
      if (wordHit(paddr, ADDR_GATE_USED))  next_prdata = gateUsed;
      if (wordHit(paddr, ADDR_GATE_OUT))   next_prdata = {24'h0, gateOut};
      if (wordHit(paddr, ADDR_SB_CTRL))    next_prdata = sbCtrl;
      if (wordHit(paddr, ADDR_SB_TIMECFG)) next_prdata = timeCfg;
      if (wordHit(paddr, ADDR_SB_STATUS))  next_prdata = {31'h0, specialOut};
      if (wordHit(paddr, ADDR_SB_ELAPSED)) next_prdata = elapsed;
      if (wordHit(paddr, ADDR_NDO_LO))     next_prdata = networkDigitalOut[31:0];
      if (wordHit(paddr, ADDR_NDO_HI))     next_prdata = networkDigitalOut[63:32];
      if (naoHit)                          next_prdata = {16'h0, naoRd};
   end

   // analog reads come from the memory register, which follows paddr in setup
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         prdata <= '0;
      end else begin
         prdata <= next_prdata;
      end
   end

endmodule : clg_cycle_logic

// ==== testbench/clg_cycle_logic_checker.sv ====
`timescale 1ns/1ns
module clg_cycle_logic_checker
   import clg_pkg::*;
(
   input wire logic                 core_clk,
   input wire logic                 arst_n,
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pwrite,
   input wire logic [11:0]          paddr,
   input wire logic [31:0]          pwdata,
   input wire logic [7:0]           gateOut,
   input wire logic                 specialOut,
   input wire logic                 scanDone,
   input wire logic [NDO_COUNT-1:0] networkDigitalOut,
   input wire logic [NAO_WIDTH-1:0] networkAnalogOut0
);
   // ---------------------------------------------------------------
   // shadow of the written configuration
   // ---------------------------------------------------------------
   logic        wrEn;
   logic [31:0] gIn, gInv, gUsed, sbCtrl;
   logic [3:0]  prvA, prvN;
   logic [3:0]  eff [8];
   logic [5:0]  sIn;
   assign wrEn = psel && penable && pwrite;
   assign sIn  = sbCtrl[5:0] & sbCtrl[13:8];  // unconnected special inputs read low
   // gates 0..3 default high when unused, the rest low
   always_comb begin
      for (int k = 0; k < 8; k++) begin
         eff[k] = ((gIn[4*k+:4] ^ gInv[4*k+:4]) & gUsed[4*k+:4]) | (~gUsed[4*k+:4] & {4{k < 4}});
      end
   end
   // track bus writes at the access edge
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         gIn    <= 32'h0;
         gInv   <= 32'h0;
         gUsed  <= 32'h0;
         sbCtrl <= 32'h0;
      end else if (wrEn) begin
         case (paddr)
            ADDR_GATE_IN:   gIn    <= pwdata;
            ADDR_GATE_INV:  gInv   <= pwdata;
            ADDR_GATE_USED: gUsed  <= pwdata;
            ADDR_SB_CTRL:   sbCtrl <= pwdata;
            default: ;
         endcase
      end
   end
   // previous-scan inputs of the edge gates, one cycle behind the design
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         prvA <= 4'hf;
         prvN <= 4'hf;
      end else if (scanDone) begin
         prvA <= eff[1];
         prvN <= eff[3];
      end
   end
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   chk_and_all_high: assert property (scanDone |-> gateOut[0] == &eff[0])
      else $error("and output wrong");
   chk_and_rise: assert property (scanDone |-> gateOut[1] == (&eff[1] && !(&prvA)))
      else $error("rising and output wrong");
   chk_nand_low: assert property (scanDone |-> gateOut[2] == !(&eff[2]))
      else $error("nand output wrong");
   chk_nand_fall: assert property (scanDone |-> gateOut[3] == (!(&eff[3]) && &prvN))
      else $error("falling nand output wrong");
   chk_or_any: assert property (scanDone |-> gateOut[4] == |eff[4])
      else $error("or output wrong");
   chk_nor_none: assert property (scanDone |-> gateOut[5] == !(|eff[5]))
      else $error("nor output wrong");
   chk_xor_differ: assert property (scanDone |-> gateOut[6] == (eff[6][0] ^ eff[6][1]))
      else $error("xor output wrong");
   chk_not_flip: assert property (scanDone && gUsed[28] |-> gateOut[7] == !eff[7][0])
      else $error("not output wrong");
   chk_scan_bound: assert property (wrEn && paddr == ADDR_SCAN && pwdata[0] |-> ##[1:4] scanDone)
      else $error("scan did not complete");
   chk_ndo_low: assert property (wrEn && paddr == ADDR_NDO_LO |=> networkDigitalOut[31:0] == $past(pwdata))
      else $error("digital out word not taken");
   chk_nao_first: assert property (wrEn && paddr == ADDR_NAO_BASE |=> networkAnalogOut0 == $past(pwdata[15:0]))
      else $error("analog out not taken");
   // the latch takes set one edge after it appears, hence two cycles of the condition
   chk_set_drives: assert property ((sIn[0] && sIn[2] && !sIn[1] && !sIn[3] && !sIn[4])[*2] |-> specialOut)
      else $error("set did not drive output");
   chk_reset_wins: assert property (sIn[1] && sIn[2] && !sIn[3] |-> !specialOut)
      else $error("reset did not clear output");
   chk_inv_flips: assert property ((sIn[0] && sIn[2] && !sIn[1] && !sIn[4])
                                   ##1 (sIn[0] && sIn[2] && !sIn[1] && !sIn[4] && sIn[3]) |-> !specialOut)
      else $error("invert did not flip output");
   cov_and_rise: cover property (scanDone && gateOut[1]);
   cov_nand_fall: cover property (scanDone && gateOut[3]);
   cov_special_high: cover property (specialOut);
endmodule : clg_cycle_logic_checker

// ==== testbench/clg_cycle_logic_bench.sv ====
`timescale 1ns/1ns
module clg_cycle_logic_bench
   import clg_pkg::*;
;
   logic                 core_clk, arst_n, psel, penable, pwrite, pready, pslverr, specialOut, scanDone;
   logic [11:0]          paddr;
   logic [31:0]          pwdata, prdata, rd;
   logic [7:0]           gateOut, e8;
   logic [NDO_COUNT-1:0] ndo;
   logic [NAO_WIDTH-1:0] nao0;
   logic [3:0]           prv, eIn;
   logic [16:0]          sbCase [6];
   int                   miscompares, numChecks;

   clg_cycle_logic i_dut (.core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .gateOut(gateOut), .specialOut(specialOut), .scanDone(scanDone),
      .networkDigitalOut(ndo), .networkAnalogOut0(nao0));

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task end_sim;
      $display("checks %0d mismatches %0d", numChecks, miscompares);
      if (miscompares == 0 && numChecks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_sim
   task check(input logic [63:0] seen, input logic [63:0] expd);
      numChecks++;
      if (seen !== expd) begin
         miscompares++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, expd);
      end
   endtask : check
   // request held until pready is seen high at a rising edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge core_clk); n++; end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin miscompares++; end_sim(); end
      rd = prdata;
      check(pslverr, 1'b0);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task rdChk(input logic [11:0] a, input logic [31:0] expd);
      apb(1'b0, a, 32'h0);
      check(rd, expd);
   endtask : rdChk
   // bits: not, xor, nor, or, nand-edge, nand, and-edge, and
   function automatic logic [7:0] expGates(input logic [3:0] v, input logic [3:0] p);
      return {~v[0], v[0] ^ v[1], ~|v, |v, (~&v) & (&p), ~&v, (&v) & ~(&p), &v};
   endfunction : expGates
   // scan completion bounded; gateOut settles with scanDone
   task scan(input logic [7:0] expd, input logic [7:0] mask);
      int n;
      apb(1'b1, ADDR_SCAN, 32'h1);
      n = 0;
      do begin @(posedge core_clk); #1; n++; end while (scanDone !== 1'b1 && n < 10);
      if (scanDone !== 1'b1) begin miscompares++; end_sim(); end
      check(gateOut & mask, expd & mask);
   endtask : scan

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   // a hang ends the run with a mismatch
   initial begin
      #4000000;
      miscompares++;
      end_sim();
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      arst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0;
      miscompares = 0; numChecks = 0;
      sbCase = '{17'h03f01, 17'h13f05, 17'h03f0d, 17'h03f07, 17'h03e05, 17'h03f09};
      repeat (8) @(posedge core_clk);
      arst_n <= 1'b1;
      rdChk(ADDR_GATE_INV, RST_GATE_INV);
      rdChk(ADDR_GATE_USED, RST_GATE_USED);
      rdChk(ADDR_SB_CTRL, RST_SB_CTRL);
      rdChk(ADDR_SB_TIMECFG, RST_TIMECFG);
      check(ndo, 64'h0);
      $display("test reset values done");
      // unused inputs: raw ones ignored, and-type see high, or-type see low
      apb(1'b1, ADDR_GATE_IN, 32'hffff_ffff);
      scan(8'h21, 8'h7f);
      $display("test unused inputs done");
      // full truth tables, plain then with mixed inversion
      apb(1'b1, ADDR_GATE_USED, 32'hffff_ffff);
      prv = 4'hf;
      for (int i = 0; i < 2; i++) begin
         apb(1'b1, ADDR_GATE_INV, (i == 1) ? 32'h5555_5555 : 32'h0);
         for (int v = 0; v < 16; v++) begin
            apb(1'b1, ADDR_GATE_IN, {8{4'(v)}});
            eIn = 4'(v) ^ ((i == 1) ? 4'h5 : 4'h0);
            e8 = expGates(eIn, prv);
            scan(e8, 8'hff);
            prv = eIn;
         end
      end
      rdChk(ADDR_GATE_OUT, {24'h0, e8});
      $display("test gate tables done");
      // set, enable, invert, reset and unconnected inputs of the special block
      // the latch follows the control word one edge after the write lands
      for (int c = 0; c < 6; c++) begin
         apb(1'b1, ADDR_SB_CTRL, {16'h0, sbCase[c][15:0]});
         @(posedge core_clk);
         #1;
         check(specialOut, sbCase[c][16]);
      end
      for (int t = 0; t < 4; t++) begin
         apb(1'b1, ADDR_SB_TIMECFG, 32'(t));
         rdChk(ADDR_SB_TIMECFG, 32'(t));
      end
      apb(1'b1, ADDR_SB_CTRL, 32'h0000_3f14);
      rdChk(ADDR_SB_ELAPSED, 32'h0);
      $display("test special block done");
      // network outputs, every analog word, unmapped place
      apb(1'b1, ADDR_NDO_LO, 32'h1234_5678);
      apb(1'b1, ADDR_NDO_HI, 32'h9abc_def0);
      #1;
      check(ndo, 64'h9abc_def0_1234_5678);
      rdChk(ADDR_NDO_HI, 32'h9abc_def0);
      for (int k = 0; k < 16; k++) apb(1'b1, ADDR_NAO_BASE + 12'(4 * k), 32'ha000 + 32'(k));
      for (int k = 0; k < 16; k++) rdChk(ADDR_NAO_BASE + 12'(4 * k), 32'ha000 + 32'(k));
      check(nao0, 16'ha000);
      apb(1'b1, 12'h100, 32'hffff_ffff);
      rdChk(12'h100, 32'h0);
      $display("test network outputs done");
      end_sim();
   end
endmodule : clg_cycle_logic_bench

bind clg_cycle_logic clg_cycle_logic_checker i_chk (.core_clk(core_clk), .arst_n(arst_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .gateOut(gateOut),
   .specialOut(specialOut), .scanDone(scanDone), .networkDigitalOut(networkDigitalOut),
   .networkAnalogOut0(networkAnalogOut0));
